/* File: sockbits_defs.svh */
// bit positions, reset values and socket count of the socket control bits
// assumes inclusion by the package and design files only
`ifndef SOCKBITS_DEFS_SVH
`define SOCKBITS_DEFS_SVH
`define NUM_SOCKETS          2
`define BIT_PROBE            8
`define BIT_AUTO_PWR_GATE    7
`define BIT_IDLE_GATING      6
`define BIT_ID_WRITE_LOCK    5
`define RST_AUTO_PWR_GATE    1'b0
`define RST_IDLE_GATING      1'b0
`define RST_ID_WRITE_LOCK    1'b1
`define RST_PROBE            1'b0
`endif

/* File: sockbits_pkg.sv */
// types shared by the socket control bit logic
// assumes sockbits_defs.svh on the include path
`include "sockbits_defs.svh"
package sockbits_pkg;
  typedef struct packed {
    logic auto_power_switch_gate;
    logic idle_socket_clock_gating_enable;
    logic id_register_write_lock;
  } ctrl_bits_t;
  typedef struct packed {
    logic card_present_cb;
    logic card_idle;
    logic cb_clock_stopped;
  } sock_state_t;
endpackage : sockbits_pkg

/* File: probe_flag.sv */
// one socket's probe-active flag, set by start and cleared by done
// assumes start and done are same-clock pulses from the probe engine
`timescale 1ns/1ps
`include "sockbits_defs.svh"
module probe_flag (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic probe_start,
  input  wire logic probe_done,
  output logic      active
);
  logic next_active;

  // a start in the same cycle as done wins so a new probe is not lost
  always_comb begin
    next_active = active;
    if (probe_done)
      next_active = 1'b0;
    if (probe_start)
      next_active = 1'b1;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)
      active <= `RST_PROBE;
    else
      active <= next_active;
  end
endmodule : probe_flag

/* File: socket_control_status_bits.sv */
// four socket control and status bits held as plain ports
// assumes probe start/done and socket state come from same-clock logic
`timescale 1ns/1ps
`include "sockbits_defs.svh"
module socket_control_status_bits (
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  input  wire logic                        ctrl_wr,
  input  wire logic [15:0]                 ctrl_wdata,
  input  wire logic                        sock_sel,
  input  wire logic [`NUM_SOCKETS-1:0]     probe_start,
  input  wire logic [`NUM_SOCKETS-1:0]     probe_done,
  input  wire logic [`NUM_SOCKETS-1:0]     pwr_ctrl_auto_en,
  input  sockbits_pkg::sock_state_t        sock_state [`NUM_SOCKETS],
  input  wire logic                        id_wr_req,
  output logic [15:0]                      ctrl_rdata,
  output sockbits_pkg::ctrl_bits_t         ctrl,
  output logic [`NUM_SOCKETS-1:0]          card_probe_active,
  output logic [`NUM_SOCKETS-1:0]          auto_power_switch_en,
  output logic [`NUM_SOCKETS-1:0]          sm_clock_run,
  output logic                             id_wr_grant
);
  import sockbits_pkg::*;

  logic [`NUM_SOCKETS-1:0] probe_q;
  ctrl_bits_t              next_ctrl;
  logic [15:0]             next_rdata;
  logic [`NUM_SOCKETS-1:0] next_probe;
  logic [`NUM_SOCKETS-1:0] next_auto_en;
  logic [`NUM_SOCKETS-1:0] next_run;
  logic                    next_grant;

  // one flag per socket, so a probe on one never shows on the other
  genvar g;
  generate
    for (g = 0; g < `NUM_SOCKETS; g++) begin : g_probe
      probe_flag probe_flag_inst (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .probe_start (probe_start[g]),
        .probe_done  (probe_done[g]),
        .active      (probe_q[g])
      );
    end
  endgenerate

  // only the three writable positions are taken from the word;
  // bit 8 has no storage here, so a write can never reach the probe flag
  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_wr) begin
      next_ctrl.auto_power_switch_gate          = ctrl_wdata[`BIT_AUTO_PWR_GATE];
      next_ctrl.idle_socket_clock_gating_enable = ctrl_wdata[`BIT_IDLE_GATING];
      next_ctrl.id_register_write_lock          = ctrl_wdata[`BIT_ID_WRITE_LOCK];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl.auto_power_switch_gate          <= `RST_AUTO_PWR_GATE;
      ctrl.idle_socket_clock_gating_enable <= `RST_IDLE_GATING;
      ctrl.id_register_write_lock          <= `RST_ID_WRITE_LOCK;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // read word follows the control bits in the same cycle as the stored copy
  always_comb begin
    next_rdata                     = 16'h0000;
    next_rdata[`BIT_PROBE]         = probe_q[sock_sel];
    next_rdata[`BIT_AUTO_PWR_GATE] = next_ctrl.auto_power_switch_gate;
    next_rdata[`BIT_IDLE_GATING]   = next_ctrl.idle_socket_clock_gating_enable;
    next_rdata[`BIT_ID_WRITE_LOCK] = next_ctrl.id_register_write_lock;
  end

  // reset word carries only the lock bit, the one control bit that resets high
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)
      ctrl_rdata <= 16'h0020;
    else
      ctrl_rdata <= next_rdata;
  end

  // pin copy of the flags; one cycle behind the flags themselves
  always_comb begin
    next_probe = probe_q;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)
      card_probe_active <= '0;
    else
      card_probe_active <= next_probe;
  end

  // run level only reports the stop; no clock is actually gated here
  always_comb begin
    next_auto_en = '0;
    next_run     = '1;
    for (int i = 0; i < `NUM_SOCKETS; i++) begin
      next_auto_en[i] = pwr_ctrl_auto_en[i] & next_ctrl.auto_power_switch_gate;
      // run unless every idle condition holds while gating is on
      next_run[i] = ~(next_ctrl.idle_socket_clock_gating_enable
                      & sock_state[i].card_present_cb
                      & sock_state[i].card_idle
                      & sock_state[i].cb_clock_stopped);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      auto_power_switch_en <= '0;
      sm_clock_run         <= '1;
    end else begin
      auto_power_switch_en <= next_auto_en;
      sm_clock_run         <= next_run;
    end
  end

  // write permission only; the id registers themselves live elsewhere
  always_comb begin
    next_grant = id_wr_req & ~next_ctrl.id_register_write_lock;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)
      id_wr_grant <= 1'b0;
    else
      id_wr_grant <= next_grant;
  end

  // sockets written out one by one so a failure names the socket, except AST_PROBE_SEL, AST_AUTO_GATE, AST_CLK_RUN and AST_PROBE_SPLIT (socket 1 only)
  AST_PROBE_SET: assert property (@(posedge mclk) disable iff (sys_rst)
    probe_start[0] |=> ##1 card_probe_active[0])
    else $error("probe flag 0 not set");

  AST_PROBE_SET1: assert property (@(posedge mclk) disable iff (sys_rst)
    probe_start[1] |=> ##1 card_probe_active[1])
    else $error("probe flag 1 not set");

  AST_PROBE_CLR: assert property (@(posedge mclk) disable iff (sys_rst)
    probe_done[0] && !probe_start[0] |=> ##1 !card_probe_active[0])
    else $error("probe flag 0 not cleared");

  AST_PROBE_CLR1: assert property (@(posedge mclk) disable iff (sys_rst)
    probe_done[1] && !probe_start[1] |=> ##1 !card_probe_active[1])
    else $error("probe flag 1 not cleared");

  AST_PROBE_SEL: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 ctrl_rdata[`BIT_PROBE] == $past(probe_q[sock_sel]))
    else $error("read probe bit wrong socket");

  AST_PROBE_SPLIT: assert property (@(posedge mclk) disable iff (sys_rst)
    !probe_start[1] && !probe_done[1] |=> $stable(probe_q[1]))
    else $error("probe flag 1 moved without its own event");

  AST_AUTO_GATE: assert property (@(posedge mclk) disable iff (sys_rst)
    !ctrl.auto_power_switch_gate |-> auto_power_switch_en == '0)
    else $error("auto power enable leaked");

  AST_AUTO_PASS: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_wr && ctrl_wdata[`BIT_AUTO_PWR_GATE] && pwr_ctrl_auto_en[0] |=> auto_power_switch_en[0])
    else $error("auto power enable 0 not passed");

  AST_AUTO_PASS1: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_wr && ctrl_wdata[`BIT_AUTO_PWR_GATE] && pwr_ctrl_auto_en[1] |=> auto_power_switch_en[1])
    else $error("auto power enable 1 not passed");

  AST_GATE_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_wr |=> ctrl.auto_power_switch_gate == $past(ctrl_wdata[`BIT_AUTO_PWR_GATE]))
    else $error("gate bit not written");

  AST_CLK_STOP: assert property (@(posedge mclk) disable iff (sys_rst)
    next_ctrl.idle_socket_clock_gating_enable && sock_state[0].card_present_cb
    && sock_state[0].card_idle && sock_state[0].cb_clock_stopped |=> !sm_clock_run[0])
    else $error("idle socket 0 still clocked");

  AST_CLK_STOP1: assert property (@(posedge mclk) disable iff (sys_rst)
    next_ctrl.idle_socket_clock_gating_enable && sock_state[1].card_present_cb
    && sock_state[1].card_idle && sock_state[1].cb_clock_stopped |=> !sm_clock_run[1])
    else $error("idle socket 1 still clocked");

  AST_CLK_RUN: assert property (@(posedge mclk) disable iff (sys_rst)
    !next_ctrl.idle_socket_clock_gating_enable |=> sm_clock_run == '1)
    else $error("socket clock stopped without gating");

  AST_SAVE_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_wr |=> ctrl.idle_socket_clock_gating_enable == $past(ctrl_wdata[`BIT_IDLE_GATING]))
    else $error("gating enable not written");

  AST_ID_LOCK: assert property (@(posedge mclk) disable iff (sys_rst)
    id_wr_grant |-> !ctrl.id_register_write_lock)
    else $error("id write while locked");

  AST_ID_GRANT: assert property (@(posedge mclk) disable iff (sys_rst)
    id_wr_req && !next_ctrl.id_register_write_lock |=> id_wr_grant)
    else $error("id write refused while unlocked");

  AST_LOCK_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_wr |=> ctrl.id_register_write_lock == $past(ctrl_wdata[`BIT_ID_WRITE_LOCK]))
    else $error("lock bit not written");

  AST_CTRL_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
    !ctrl_wr |=> $stable(ctrl))
    else $error("control bits moved without a write");

  AST_RO_PROBE: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_wr && !probe_start[0] && !probe_done[0] |=> $stable(probe_q[0]))
    else $error("write changed probe bit 0");

  AST_RO_PROBE1: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_wr && !probe_start[1] && !probe_done[1] |=> $stable(probe_q[1]))
    else $error("write changed probe bit 1");

  COV_PROBE: cover property (@(posedge mclk) disable iff (sys_rst)
    probe_start[0] ##[1:20] probe_done[0]);
  COV_GATE: cover property (@(posedge mclk) disable iff (sys_rst)
    auto_power_switch_en[0]);
  COV_STOP: cover property (@(posedge mclk) disable iff (sys_rst) !sm_clock_run[0]);
  COV_UNLOCK: cover property (@(posedge mclk) disable iff (sys_rst) id_wr_grant);
  COV_SEL1: cover property (@(posedge mclk) disable iff (sys_rst)
    sock_sel && ctrl_rdata[`BIT_PROBE]);
endmodule : socket_control_status_bits

/* File: socket_control_status_bits_tb.sv */
// self-checking bench for the socket control and status bits
// assumes the package, sockbits_defs.svh and the design files are compiled first
`timescale 1ns/1ps
module socket_control_status_bits_tb;
  import sockbits_pkg::*;
  logic        mclk = 1'b0, sys_rst = 1'b1, ctrl_wr = 1'b0, sock_sel = 1'b0, id_wr_req = 1'b0;
  logic [15:0] ctrl_wdata = 16'h0000;
  logic [1:0]  probe_start = 2'h0, probe_done = 2'h0, pwr_ctrl_auto_en = 2'h3;
  sock_state_t sock_state [2] = '{default: '0};
  logic [15:0] ctrl_rdata;
  ctrl_bits_t  ctrl;
  logic [1:0]  card_probe_active, auto_power_switch_en, sm_clock_run;
  logic        id_wr_grant;
  int          n_errors = 0, cmp_count = 0;

  always #50 mclk = ~mclk;

  socket_control_status_bits socket_control_status_bits_inst (
    .mclk(mclk), .sys_rst(sys_rst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .sock_sel(sock_sel), .probe_start(probe_start), .probe_done(probe_done),
    .pwr_ctrl_auto_en(pwr_ctrl_auto_en), .sock_state(sock_state), .id_wr_req(id_wr_req),
    .ctrl_rdata(ctrl_rdata), .ctrl(ctrl), .card_probe_active(card_probe_active),
    .auto_power_switch_en(auto_power_switch_en), .sm_clock_run(sm_clock_run),
    .id_wr_grant(id_wr_grant));

  // inputs always move 1 ns after the edge, never on it
  task step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one-cycle write strobe, answer visible right after return
  task wr(input logic [15:0] d);
    ctrl_wr = 1'b1;
    ctrl_wdata = d;
    step(1);
    ctrl_wr = 1'b0;
  endtask : wr

  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  initial begin
    step(10);
    sys_rst = 1'b0;
    step(1);
    chk("rdata", 16'h0020, ctrl_rdata);
    chk("probe", 16'h0000, 16'(card_probe_active));
    chk("auto_en", 16'h0000, 16'(auto_power_switch_en));
    chk("run", 16'h0003, 16'(sm_clock_run));
    chk("grant", 16'h0000, 16'(id_wr_grant));
    chk("ctrl", 16'h0001, 16'(ctrl));
    $display("test reset done");
    id_wr_req = 1'b1;
    wr(16'h0080);
    chk("rdata", 16'h0080, ctrl_rdata);
    chk("ctrl", 16'h0004, 16'(ctrl));
    chk("auto_en", 16'h0003, 16'(auto_power_switch_en));
    chk("grant", 16'h0001, 16'(id_wr_grant));
    // only socket 0 asks for auto power now; the gate must pass just that one
    pwr_ctrl_auto_en = 2'h1;
    step(1);
    chk("auto_en", 16'h0001, 16'(auto_power_switch_en));
    // bit8 written high must not reach the read-only flag
    wr(16'hffff);
    chk("rdata", 16'h00e0, ctrl_rdata);
    chk("ctrl", 16'h0007, 16'(ctrl));
    chk("probe", 16'h0000, 16'(card_probe_active));
    chk("grant", 16'h0000, 16'(id_wr_grant));
    $display("test control writes done");
    sock_state[0] = '{1'b1, 1'b1, 1'b1};
    sock_state[1] = '{1'b1, 1'b1, 1'b0};
    step(1);
    chk("run", 16'h0002, 16'(sm_clock_run));
    wr(16'h0000);
    chk("run", 16'h0003, 16'(sm_clock_run));
    chk("auto_en", 16'h0000, 16'(auto_power_switch_en));
    chk("grant", 16'h0001, 16'(id_wr_grant));
    $display("test gating done");
    probe_start = 2'h2;
    step(1);
    probe_start = 2'h0;
    step(1);
    chk("probe", 16'h0002, 16'(card_probe_active));
    chk("rdata", 16'h0000, ctrl_rdata);
    sock_sel = 1'b1;
    wr(16'h0000);
    chk("rdata", 16'h0100, ctrl_rdata);
    chk("probe", 16'h0002, 16'(card_probe_active));
    probe_done = 2'h2;
    step(1);
    probe_done = 2'h0;
    step(1);
    chk("probe", 16'h0000, 16'(card_probe_active));
    chk("rdata", 16'h0000, ctrl_rdata);
    // socket 0: start and done in one cycle, the start must win
    sock_sel = 1'b0;
    probe_start = 2'h1;
    probe_done = 2'h1;
    step(1);
    probe_start = 2'h0;
    probe_done = 2'h0;
    step(1);
    chk("probe", 16'h0001, 16'(card_probe_active));
    chk("rdata", 16'h0100, ctrl_rdata);
    probe_done = 2'h1;
    step(1);
    probe_done = 2'h0;
    step(1);
    chk("probe", 16'h0000, 16'(card_probe_active));
    chk("rdata", 16'h0000, ctrl_rdata);
    $display("test probe done");
    finish_test();
  end
endmodule : socket_control_status_bits_tb
